// *** rtl/sccu_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the clock unit
`ifndef SCCU_CFG_SVH
`define SCCU_CFG_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCCU_OFS_MAIN 12'h000
`define SCCU_OFS_SLOW 12'h004
`define SCCU_OFS_PLL 12'h008
`define SCCU_OFS_FLCONF 12'h00C
`define SCCU_OFS_FLSYNC 12'h010
`define SCCU_OFS_STAT 12'h014
`define SCCU_OFS_IEN 12'h018
`define SCCU_OFS_IMASK 12'h01C
`define SCCU_OFS_IPEND 12'h020
`define SCCU_OFS_ICLR 12'h024
`define SCCU_OFS_UNLOCK 12'h028
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCCU_B_EN 0
`define SCCU_B_MODE 1
`define SCCU_B_ONE_KHZ_OUTPUT_ENABLE 2
`define SCCU_B_SLOW_OUTPUT_ENABLE 3
`define SCCU_B_SLOW_PIN_PAIR_SELECT 4
`define SCCU_F_SU 11:8
`define SCCU_F_PREF 2:1
`define SCCU_F_POPT 7:4
`define SCCU_F_PDIV 11:8
`define SCCU_F_PMUL 19:16
`define SCCU_F_COARSE 15:8
`define SCCU_F_FINE 25:16
`define SCCU_F_KEY 31:24
`define SCCU_F_KOFS 11:0
`define SCCU_UNLOCK_KEY 8'hAA
// Status / interrupt bit positions
`define SCCU_S_MAIN 0
`define SCCU_S_SLOW 1
`define SCCU_S_LOCK 2
`define SCCU_S_LOST 3
`define SCCU_S_FLRDY 4
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCCU_RST_MAIN 32'h0000_0000
`define SCCU_RST_SLOW 32'h0000_0008
`define SCCU_RST_PLL 32'h0000_0000
`define SCCU_RST_FL 32'h0000_0000
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCCU_PCLK_NS 100
`define SCCU_SU_UNIT_NS 1000
`define SCCU_SU_CYC ((`SCCU_SU_UNIT_NS+`SCCU_PCLK_NS-1)/`SCCU_PCLK_NS)
`define SCCU_FL_SYNC_NS 400
`define SCCU_FL_SYNC_CYC ((`SCCU_FL_SYNC_NS+`SCCU_PCLK_NS-1)/`SCCU_PCLK_NS)
`endif

// *** rtl/sccu_pkg.sv ***
// Types shared by the clock unit modules
package sccu_pkg;
  // Frequency-loop crossing state
  typedef enum logic [0:0] {
    SCCU_FL_IDLE = 1'b0,
    SCCU_FL_BUSY = 1'b1
  } sccu_fl_state_t;
endpackage : sccu_pkg

// *** rtl/sccu_startup.sv ***
// Oscillator start-up mask with running-level synchroniser
`timescale 1ns/1ps
`include "sccu_cfg.svh"
module sccu_startup
  import sccu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic osc_run,
  input wire logic [3:0] su_sel,
  output logic ready,
  output logic clk_gate
);
  // ----------------------------------------------------------------
  // Running level crossing
  // ----------------------------------------------------------------
  logic run_m_q; // First stage, read only by second
  logic run_s_q; // Usable running level
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic rdy_q;
  logic rdy_d;
  logic [15:0] target;

  // Start-up length: su_sel+1 units of 10 pclk cycles each
  assign target = 16'(({12'h000, su_sel} + 16'h0001) * `SCCU_SU_CYC);

  // Next count; any drop of enable or running restarts the wait
  always_comb
  begin
    cnt_d = cnt_q;
    rdy_d = rdy_q;
    if (!en || !run_s_q)
    begin
      cnt_d = 16'h0000;
      rdy_d = 1'b0;
    end
    else if (cnt_q >= target)
      rdy_d = 1'b1;
    else
      cnt_d = cnt_q + 16'h0001;
  end

  // Synchroniser and counter registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_m_q <= 1'b0;
      run_s_q <= 1'b0;
      cnt_q <= 16'h0000;
      rdy_q <= 1'b0;
    end
    else
    begin
      run_m_q <= osc_run;
      run_s_q <= run_m_q;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  assign ready = rdy_q;
  // Unstable cycles never pass before ready
  assign clk_gate = rdy_q & en;
endmodule : sccu_startup

// *** rtl/sccu_clock_unit.sv ***
// Clock source control: main, slow, phase and frequency loops, APB slave
//
// Contract
// - Oscillators start disabled, pins left to GPIO
// - Enabled oscillator owns its crystal pins
// - Enable and mode bits; sleep forces off
// - Mask oscillator output during start-up
// - Main ready flag, rising edge interrupt
// - Enable write sets interrupt mask bits
// - Slow oscillator survives sleep, non-POR resets
// - Slow ready flag, rising edge interrupt
// - 1 kHz and 32 kHz output enables
// - Pin-pair select for slow oscillator
// - Phase loop off; clock masked until lock
// - Phase loop writes need unlock
// - Software keeps multiplier above one
// - Options field: halve, wide bandwidth
// - Writes other than disable discarded while phase loop enabled
// - Lock and lock-lost flags, interrupts
// - Frequency loop writes need unlock
// - Ignore frequency writes while enabled and not ready
// - Sync request presents synchronised values
// - Disabled loop never sets ready
// - Open loop follows coarse and fine
// - Closed loop makes coarse, fine read-only
`timescale 1ns/1ps
`include "sccu_cfg.svh"
module sccu_clock_unit
  import sccu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic sleep_osc_off,
  input wire logic main_osc_running,
  output logic main_osc_enable,
  output logic main_osc_mode,
  output logic main_crystal_in_own,
  output logic main_crystal_out_own,
  output logic main_clk_gate,
  input wire logic slow_osc_running,
  output logic slow_osc_enable,
  output logic slow_osc_mode,
  output logic slow_crystal_in_own,
  output logic slow_crystal_out_own,
  output logic slow_crystal_in_alt_own,
  output logic slow_crystal_out_alt_own,
  output logic one_khz_output_enable,
  output logic slow_output_enable,
  output logic slow_clk_gate,
  input wire logic phase_loop_lock_raw,
  output logic phase_loop_enable,
  output logic [1:0] phase_loop_ref_select,
  output logic [3:0] phase_loop_options,
  output logic [3:0] phase_loop_divider,
  output logic [3:0] phase_loop_multiplier,
  output logic phase_loop_clk_gate,
  input wire logic [7:0] freq_loop_tuned_coarse,
  input wire logic [9:0] freq_loop_tuned_fine,
  output logic freq_loop_enable,
  output logic freq_loop_mode,
  output logic [7:0] freq_loop_coarse,
  output logic [9:0] freq_loop_fine
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic wr_acc; // Write in access phase
  logic rd_setup; // Read in setup phase
  logic mapped; // Address decodes
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [31:0] main_q; // main_osc_control
  logic [31:0] main_d;
  logic [31:0] slow_q; // slow_osc_control, POR only
  logic [31:0] slow_d;
  logic [31:0] pll_q; // phase_loop_control
  logic [31:0] pll_d;
  logic [31:0] fl_q; // freq_loop_config
  logic [31:0] fl_d;
  logic [31:0] fl_shadow_q; // Synchronised readback
  logic [31:0] fl_shadow_d;
  logic [4:0] mask_q; // irq_mask_reg
  logic [4:0] mask_d;
  logic [4:0] pend_q; // Sticky interrupt events
  logic [4:0] pend_d;
  logic [4:0] stat_prev_q; // Status one cycle ago
  logic [4:0] stat;
  logic [4:0] rise;
  logic armed_q; // Unlock key seen
  logic armed_d;
  logic [11:0] arm_ofs_q; // Offset the key names
  logic [11:0] arm_ofs_d;
  logic lock_m_q; // First stage, read only by second
  logic lock_s_q;
  logic lost_q; // phase_loop_lock_lost_flag
  logic lost_d;
  logic relock_q; // Lock seen in the previous cycle while enabled
  logic relock_d;
  logic [7:0] tc_m_q; // Tuned words crossing
  logic [7:0] tc_s_q;
  logic [9:0] tf_m_q;
  logic [9:0] tf_s_q;
  sccu_fl_state_t fl_st_q;
  sccu_fl_state_t fl_st_d;
  logic [3:0] fl_cnt_q;
  logic [3:0] fl_cnt_d;
  logic fl_rdy_q; // freq_loop_sync_ready
  logic fl_rdy_d;
  logic main_rdy;
  logic slow_rdy;
  logic pll_ok; // Unlock satisfied for this write
  logic fl_ok;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  // Zero-wait slave; read data was latched in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign pll_ok = armed_q && (arm_ofs_q == `SCCU_OFS_PLL);
  assign fl_ok = armed_q && (arm_ofs_q == `SCCU_OFS_FLCONF);

  // Read mux and address map
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `SCCU_OFS_MAIN: rd_mux = main_q;
      `SCCU_OFS_SLOW: rd_mux = slow_q;
      `SCCU_OFS_PLL: rd_mux = pll_q;
      `SCCU_OFS_FLCONF: rd_mux = fl_shadow_q;
      `SCCU_OFS_FLSYNC: rd_mux = 32'h0000_0000;
      `SCCU_OFS_STAT: rd_mux = {27'h0, stat};
      `SCCU_OFS_IEN: rd_mux = 32'h0000_0000;
      `SCCU_OFS_IMASK: rd_mux = {27'h0, mask_q};
      `SCCU_OFS_IPEND: rd_mux = {27'h0, pend_q};
      `SCCU_OFS_ICLR: rd_mux = 32'h0000_0000;
      `SCCU_OFS_UNLOCK: rd_mux = 32'h0000_0000;
      default: mapped = 1'b0; // Unmapped reads zero, error
    endcase
  end

  // ----------------------------------------------------------------
  // Register file next state
  // ----------------------------------------------------------------
  always_comb
  begin
    prdata_d = rd_setup ? rd_mux : prdata_q;
    main_d = main_q;
    pll_d = pll_q;
    fl_d = fl_q;
    mask_d = mask_q;
    armed_d = armed_q;
    arm_ofs_d = arm_ofs_q;
    if (wr_acc)
    begin
      // Any write consumes the key, so it covers one write only
      armed_d = 1'b0;
      unique case (paddr)
        `SCCU_OFS_MAIN: main_d = pwdata;
        `SCCU_OFS_PLL:
        begin
          if (pll_ok)
          begin
            if (!pll_q[`SCCU_B_EN])
              pll_d = pwdata;
            else if (!pwdata[`SCCU_B_EN])
              pll_d[`SCCU_B_EN] = 1'b0;
          end
        end
        `SCCU_OFS_FLCONF:
        begin
          // Disabled loop accepts re-enable without ready
          if (fl_ok && (fl_rdy_q || !fl_q[`SCCU_B_EN]))
          begin
            fl_d = pwdata;
            if (fl_q[`SCCU_B_MODE] && pwdata[`SCCU_B_MODE])
            begin
              // Tuner owns the calibration fields
              fl_d[`SCCU_F_COARSE] = fl_q[`SCCU_F_COARSE];
              fl_d[`SCCU_F_FINE] = fl_q[`SCCU_F_FINE];
            end
          end
        end
        `SCCU_OFS_IEN: mask_d = mask_q | pwdata[4:0];
        `SCCU_OFS_IMASK: mask_d = mask_q & ~pwdata[4:0];
        `SCCU_OFS_UNLOCK:
        begin
          if (pwdata[`SCCU_F_KEY] == `SCCU_UNLOCK_KEY)
          begin
            armed_d = 1'b1;
            arm_ofs_d = pwdata[`SCCU_F_KOFS];
          end
        end
        default: ; // Other offsets store nothing here
      endcase
    end
    fl_d[31:26] = 6'h00; // Bits 31:26 stay zero
  end

  // Slow control, written alone by software
  always_comb
  begin
    slow_d = slow_q;
    if (wr_acc && (paddr == `SCCU_OFS_SLOW))
      slow_d = pwdata;
    slow_d[31:12] = 20'h00000;
  end

  // Registers cleared by presetn, not by por_n alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      main_q <= `SCCU_RST_MAIN;
      pll_q <= `SCCU_RST_PLL;
      fl_q <= `SCCU_RST_FL;
      mask_q <= 5'h00;
      armed_q <= 1'b0;
      arm_ofs_q <= 12'h000;
    end
    else
    begin
      prdata_q <= prdata_d;
      main_q <= main_d;
      pll_q <= pll_d;
      fl_q <= fl_d;
      mask_q <= mask_d;
      armed_q <= armed_d;
      arm_ofs_q <= arm_ofs_d;
    end
  end

  // Slow oscillator control survives all but power-on reset
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      slow_q <= `SCCU_RST_SLOW;
    else
      slow_q <= slow_d;
  end

  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // Main and slow oscillators
  // ----------------------------------------------------------------
  // Sleep drops the enable, so wake-up repeats the start-up wait
  assign main_osc_enable = main_q[`SCCU_B_EN] & ~sleep_osc_off;
  assign main_osc_mode = main_q[`SCCU_B_MODE];
  assign main_crystal_in_own = main_osc_enable;
  // External clock mode leaves the output pin to GPIO
  assign main_crystal_out_own = main_osc_enable & ~main_q[`SCCU_B_MODE];

  sccu_startup u_main_su (
    .clk(pclk),
    .rst_n(presetn),
    .en(main_osc_enable),
    .osc_run(main_osc_running),
    .su_sel(main_q[`SCCU_F_SU]),
    .ready(main_rdy),
    .clk_gate(main_clk_gate)
  );

  // No sleep input: the slow oscillator runs in every mode
  assign slow_osc_enable = slow_q[`SCCU_B_EN];
  assign slow_osc_mode = slow_q[`SCCU_B_MODE];
  assign slow_crystal_in_own = slow_osc_enable & ~slow_q[`SCCU_B_SLOW_PIN_PAIR_SELECT];
  assign slow_crystal_out_own = slow_crystal_in_own & ~slow_osc_mode;
  // Alternate pair is the one kept powered in shutdown
  assign slow_crystal_in_alt_own = slow_osc_enable &
                                   slow_q[`SCCU_B_SLOW_PIN_PAIR_SELECT];
  assign slow_crystal_out_alt_own = slow_crystal_in_alt_own & ~slow_osc_mode;

  sccu_startup u_slow_su (
    .clk(pclk),
    .rst_n(por_n),
    .en(slow_osc_enable),
    .osc_run(slow_osc_running),
    .su_sel(slow_q[`SCCU_F_SU]),
    .ready(slow_rdy),
    .clk_gate(slow_clk_gate)
  );

  assign one_khz_output_enable = slow_rdy & slow_q[`SCCU_B_ONE_KHZ_OUTPUT_ENABLE];
  assign slow_output_enable = slow_rdy & slow_q[`SCCU_B_SLOW_OUTPUT_ENABLE];

  // ----------------------------------------------------------------
  // Phase loop
  // ----------------------------------------------------------------
  assign phase_loop_enable = pll_q[`SCCU_B_EN];
  assign phase_loop_ref_select = pll_q[`SCCU_F_PREF];
  // Option bits carry range, halving and wide bandwidth
  assign phase_loop_options = pll_q[`SCCU_F_POPT];
  // Analog side forms (mul+1)/div, or 2(mul+1) for div zero
  assign phase_loop_divider = pll_q[`SCCU_F_PDIV];
  assign phase_loop_multiplier = pll_q[`SCCU_F_PMUL];

  // Lock tracking and loss detection
  always_comb
  begin
    lost_d = lost_q;
    relock_d = relock_q;
    if (!phase_loop_enable)
    begin
      relock_d = 1'b0;
      lost_d = 1'b0;
    end
    else if (lock_s_q)
    begin
      relock_d = 1'b1;
      lost_d = 1'b0; // Lock regained clears the loss
    end
    else if (relock_q)
    begin
      relock_d = 1'b0;
      lost_d = 1'b1;
    end
  end

  // Lock synchroniser and flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_m_q <= 1'b0;
      lock_s_q <= 1'b0;
      lost_q <= 1'b0;
      relock_q <= 1'b0;
    end
    else
    begin
      lock_m_q <= phase_loop_lock_raw;
      lock_s_q <= lock_m_q;
      lost_q <= lost_d;
      relock_q <= relock_d;
    end
  end

  // Undefined frequency never reaches the logic
  assign phase_loop_clk_gate = phase_loop_enable & lock_s_q &
                               relock_q;

  // ----------------------------------------------------------------
  // Frequency loop crossing
  // ----------------------------------------------------------------
  assign freq_loop_enable = fl_q[`SCCU_B_EN];
  assign freq_loop_mode = fl_q[`SCCU_B_MODE];
  // Open loop drives the fields straight to the oscillator
  assign freq_loop_coarse = fl_q[`SCCU_F_COARSE];
  assign freq_loop_fine = fl_q[`SCCU_F_FINE];

  // Busy for the crossing latency after a write or sync request
  always_comb
  begin
    fl_st_d = fl_st_q;
    fl_cnt_d = fl_cnt_q;
    fl_rdy_d = fl_rdy_q;
    fl_shadow_d = fl_shadow_q;
    unique case (fl_st_q)
      SCCU_FL_IDLE:
      begin
        if (wr_acc && ((paddr == `SCCU_OFS_FLSYNC && pwdata[0]) ||
                       paddr == `SCCU_OFS_FLCONF))
        begin
          fl_st_d = SCCU_FL_BUSY;
          fl_cnt_d = 4'h0;
          fl_rdy_d = 1'b0;
        end
      end
      SCCU_FL_BUSY:
      begin
        if (fl_cnt_q == 4'(`SCCU_FL_SYNC_CYC - 1))
        begin
          fl_st_d = SCCU_FL_IDLE;
          fl_shadow_d = fl_q;
          if (fl_q[`SCCU_B_MODE])
          begin
            fl_shadow_d[`SCCU_F_COARSE] = tc_s_q;
            fl_shadow_d[`SCCU_F_FINE] = tf_s_q;
          end
        end
        else
          fl_cnt_d = fl_cnt_q + 4'h1;
      end
    endcase
    // Ready only for an enabled loop, idle crossing
    if (!fl_q[`SCCU_B_EN])
      fl_rdy_d = 1'b0;
    else if (fl_st_d == SCCU_FL_IDLE)
      fl_rdy_d = 1'b1;
  end

  // Crossing state and tuned-word stages
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fl_st_q <= SCCU_FL_IDLE;
      fl_cnt_q <= 4'h0;
      fl_rdy_q <= 1'b0;
      fl_shadow_q <= `SCCU_RST_FL;
      tc_m_q <= 8'h00;
      tc_s_q <= 8'h00;
      tf_m_q <= 10'h000;
      tf_s_q <= 10'h000;
    end
    else
    begin
      fl_st_q <= fl_st_d;
      fl_cnt_q <= fl_cnt_d;
      fl_rdy_q <= fl_rdy_d;
      fl_shadow_q <= fl_shadow_d;
      // Tuner words assumed steady across the sync window
      tc_m_q <= freq_loop_tuned_coarse;
      tc_s_q <= tc_m_q;
      tf_m_q <= freq_loop_tuned_fine;
      tf_s_q <= tf_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  assign stat = {fl_rdy_q, lost_q, lock_s_q & phase_loop_enable,
                 slow_rdy, main_rdy};
  assign rise = stat & ~stat_prev_q;

  // New event wins over a clear in the same cycle
  always_comb
  begin
    pend_d = pend_q;
    if (wr_acc && (paddr == `SCCU_OFS_ICLR))
      pend_d = pend_q & ~pwdata[4:0];
    pend_d = pend_d | rise;
  end

  // Edge history and sticky events
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_prev_q <= 5'h00;
      pend_q <= 5'h00;
    end
    else
    begin
      stat_prev_q <= stat;
      pend_q <= pend_d;
    end
  end

  assign irq = |(pend_q & mask_q);
endmodule : sccu_clock_unit

// *** tb/sccu_xtal_model.sv ***
// Behavioural crystal, clock source and loop tuner beside the clock unit
`timescale 1ns/1ps
module sccu_xtal_model
  import sccu_pkg::*;
#(
  parameter int DLY = 3 // Start-up lag of a crystal is DLY+1 cycles
)
(
  input wire logic clk,
  input wire logic main_en,
  input wire logic slow_en,
  input wire logic pll_en,
  input wire logic lock_kill,
  output logic main_run,
  output logic slow_run,
  output logic lock_raw,
  output logic [7:0] coarse,
  output logic [9:0] fine
);
  logic [7:0] main_sh;
  logic [7:0] slow_sh;
  // Slow start, instant stop
  always_ff @(posedge clk)
  begin
    main_sh <= main_en ? {main_sh[6:0], 1'b1} : 8'h00;
    slow_sh <= slow_en ? {slow_sh[6:0], 1'b1} : 8'h00;
    lock_raw <= pll_en & ~lock_kill;
  end
  assign main_run = main_sh[DLY];
  assign slow_run = slow_sh[DLY];
  assign coarse = 8'h5A;
  assign fine = 10'h155;
endmodule : sccu_xtal_model

// *** tb/sccu_clock_unit_props.sv ***
// Port checks of the clock unit, bound to its top module
`timescale 1ns/1ps
module sccu_clock_unit_chk
  import sccu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_osc_off,
  input wire logic main_osc_running,
  input wire logic main_osc_enable,
  input wire logic main_osc_mode,
  input wire logic main_crystal_in_own,
  input wire logic main_crystal_out_own,
  input wire logic main_clk_gate,
  input wire logic slow_osc_enable,
  input wire logic slow_crystal_in_own,
  input wire logic slow_crystal_in_alt_own,
  input wire logic phase_loop_lock_raw,
  input wire logic phase_loop_enable,
  input wire logic [3:0] phase_loop_divider,
  input wire logic [3:0] phase_loop_multiplier,
  input wire logic phase_loop_clk_gate
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_main_dead;
    !main_osc_running [*5];
  endsequence
  sequence s_lock_gone;
    !phase_loop_lock_raw [*4];
  endsequence
  a_main_in_own:
    assert property (main_crystal_in_own == main_osc_enable)
    else $error("main input pin ownership wrong");
  a_main_out_free:
    assert property (main_crystal_out_own ==
      (main_osc_enable && !main_osc_mode))
    else $error("main output pin ownership wrong");
  a_sleep_off:
    assert property (sleep_osc_off |-> !main_osc_enable)
    else $error("main oscillator runs in sleep");
  a_gate_needs_en:
    assert property (main_clk_gate |-> main_osc_enable)
    else $error("main clock passes while disabled");
  a_main_masked:
    assert property (s_main_dead |-> !main_clk_gate)
    else $error("main clock passes without a running crystal");
  a_slow_alt:
    assert property (slow_crystal_in_alt_own |->
      slow_osc_enable && !slow_crystal_in_own)
    else $error("slow pin pairs both claimed");
  a_pll_masked:
    assert property (s_lock_gone |-> !phase_loop_clk_gate)
    else $error("loop clock passes without lock");
  a_pll_gate_en:
    assert property (phase_loop_clk_gate |-> phase_loop_enable)
    else $error("loop clock passes while disabled");
  a_pll_frozen:
    assert property (phase_loop_enable && $past(phase_loop_enable) |->
      $stable(phase_loop_multiplier) && $stable(phase_loop_divider))
    else $error("loop setting changed while enabled");
endmodule : sccu_clock_unit_chk

bind sccu_clock_unit sccu_clock_unit_chk chk_i (.*);

// *** tb/test_osc_pll_dfll_clock_control.sv ***
// Self-checking bench of the clock unit over APB
`timescale 1ns/1ps
`include "sccu_cfg.svh"
module test_osc_pll_dfll_clock_control
  import sccu_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, psel = 1'b0;
  logic penable = 1'b0, pwrite = 1'b0, sleep_osc_off = 1'b0;
  logic lock_kill = 1'b0, serr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic pready, pslverr, irq, main_osc_running, slow_osc_running;
  logic phase_loop_lock_raw, main_osc_enable, main_osc_mode;
  logic main_crystal_in_own, main_crystal_out_own, main_clk_gate;
  logic slow_osc_enable, slow_osc_mode, slow_crystal_in_own;
  logic slow_crystal_out_own, slow_crystal_in_alt_own;
  logic slow_crystal_out_alt_own, one_khz_output_enable;
  logic slow_output_enable, slow_clk_gate, phase_loop_enable;
  logic phase_loop_clk_gate, freq_loop_enable, freq_loop_mode;
  logic [1:0] phase_loop_ref_select;
  logic [3:0] phase_loop_options, phase_loop_divider, phase_loop_multiplier;
  logic [7:0] freq_loop_tuned_coarse, freq_loop_coarse;
  logic [9:0] freq_loop_tuned_fine, freq_loop_fine;
  int fail_count = 0, tests_run = 0;
  always #50 pclk = ~pclk; // 10 MHz
  sccu_clock_unit sccu_clock_unit_i (.*);
  sccu_xtal_model sccu_xtal_model_i (.clk(pclk),
    .main_en(main_osc_enable), .slow_en(slow_osc_enable),
    .pll_en(phase_loop_enable), .lock_kill(lock_kill),
    .main_run(main_osc_running), .slow_run(slow_osc_running),
    .lock_raw(phase_loop_lock_raw), .coarse(freq_loop_tuned_coarse),
    .fine(freq_loop_tuned_fine));
  // ------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // One transfer; with hold set, next setup follows at once, no release
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input bit hold);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    serr = pslverr;
    if (!hold)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input bit hold = 1'b0);
    apb(1'b1, a, d, hold);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000, 1'b0);
  endtask : rd
  task automatic key(input logic [11:0] a);
    wr(`SCCU_OFS_UNLOCK, {`SCCU_UNLOCK_KEY, 12'h000, a}, 1'b1);
  endtask : key
  task automatic wait_st(input int b); // Bounded poll of a status bit
    int n;
    n = 0;
    rd(`SCCU_OFS_STAT);
    while (rdat[b] !== 1'b1 && n < 100)
    begin
      rd(`SCCU_OFS_STAT);
      n++;
    end
  endtask : wait_st
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_reset;
    rd(`SCCU_OFS_MAIN);
    chk(rdat, `SCCU_RST_MAIN);
    rd(`SCCU_OFS_SLOW);
    chk(rdat, 32'h0000_0008);
    chk(32'({main_crystal_in_own, slow_crystal_in_own}), 32'h0);
    rd(12'h0FC); // Unmapped place reads zero
    chk(rdat, 32'h0000_0000);
    chk(32'(serr), 32'h1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_main;
    wr(`SCCU_OFS_IEN, 32'h0000_0001);
    rd(`SCCU_OFS_IMASK);
    chk(rdat, 32'h0000_0001);
    wr(`SCCU_OFS_MAIN, 32'h0000_0001);
    chk(32'(main_clk_gate), 32'h0);
    chk(32'({main_crystal_in_own, main_crystal_out_own}), 32'h3);
    wait_st(`SCCU_S_MAIN);
    chk(32'(main_clk_gate), 32'h1);
    rd(`SCCU_OFS_IPEND);
    chk(32'({rdat[0], irq}), 32'h3);
    wr(`SCCU_OFS_ICLR, 32'h0000_0001);
    wr(`SCCU_OFS_MAIN, 32'h0000_0003); // External clock mode
    chk(32'({main_crystal_in_own, main_crystal_out_own}), 32'h2);
    sleep_osc_off <= 1'b1;
    @(negedge pclk);
    chk(32'(main_osc_enable), 32'h0);
    @(posedge pclk);
    sleep_osc_off <= 1'b0;
    wr(`SCCU_OFS_MAIN, 32'h0000_0000);
    $display("main oscillator test done");
  endtask : t_main
  task automatic t_slow;
    wr(`SCCU_OFS_SLOW, 32'h0000_001C);
    wr(`SCCU_OFS_SLOW, 32'h0000_001D);
    wait_st(`SCCU_S_SLOW);
    chk(32'(rdat[1]), 32'h1);
    chk(32'({slow_crystal_in_alt_own, slow_crystal_in_own}), 32'h2);
    chk(32'(one_khz_output_enable), 32'h1);
    presetn <= 1'b0; // A plain reset must not stop the slow crystal
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`SCCU_OFS_SLOW);
    chk(rdat, 32'h0000_001D);
    $display("slow oscillator test done");
  endtask : t_slow
  task automatic t_pll;
    wr(`SCCU_OFS_PLL, 32'h0003_0110);
    rd(`SCCU_OFS_PLL);
    chk(rdat, 32'h0000_0000);
    key(`SCCU_OFS_PLL);
    wr(`SCCU_OFS_PLL, 32'h0003_0110);
    chk(32'({phase_loop_multiplier, phase_loop_divider,
      phase_loop_options}), 32'h311);
    key(`SCCU_OFS_PLL);
    wr(`SCCU_OFS_PLL, 32'h0003_0111);
    chk(32'(phase_loop_clk_gate), 32'h0);
    wait_st(`SCCU_S_LOCK);
    chk(32'({rdat[2], phase_loop_clk_gate}), 32'h3);
    key(`SCCU_OFS_PLL);
    wr(`SCCU_OFS_PLL, 32'h0005_0111);
    rd(`SCCU_OFS_PLL);
    chk(rdat, 32'h0003_0111);
    lock_kill <= 1'b1;
    wait_st(`SCCU_S_LOST);
    chk(32'(rdat[3:2]), 32'h2);
    key(`SCCU_OFS_PLL);
    wr(`SCCU_OFS_PLL, 32'h0000_0000);
    chk(32'(phase_loop_enable), 32'h0);
    lock_kill <= 1'b0;
    $display("phase loop test done");
  endtask : t_pll
  task automatic t_fl;
    key(`SCCU_OFS_FLCONF);
    wr(`SCCU_OFS_FLCONF, 32'h0000_0001);
    wait_st(`SCCU_S_FLRDY);
    chk(32'(rdat[4]), 32'h1);
    key(`SCCU_OFS_FLCONF);
    wr(`SCCU_OFS_FLCONF, 32'h0000_2001, 1'b1);
    key(`SCCU_OFS_FLCONF);
    wr(`SCCU_OFS_FLCONF, 32'h0000_3001);
    chk(32'({freq_loop_coarse, freq_loop_fine}), 32'h8000);
    chk(32'(freq_loop_coarse), 32'h20);
    wait_st(`SCCU_S_FLRDY);
    wr(`SCCU_OFS_FLSYNC, 32'h0000_0001);
    wait_st(`SCCU_S_FLRDY);
    rd(`SCCU_OFS_FLCONF);
    chk(rdat, 32'h0000_2001);
    key(`SCCU_OFS_FLCONF);
    wr(`SCCU_OFS_FLCONF, 32'h0000_0000);
    repeat (10) @(posedge pclk);
    rd(`SCCU_OFS_STAT);
    chk(32'(rdat[4]), 32'h0);
    $display("frequency loop test done");
  endtask : t_fl
  // ------------------------------------------------
  // Verdict and run control
  // ------------------------------------------------
  task automatic final_report;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_main;
    t_slow;
    t_pll;
    t_fl;
    final_report;
  end
  // Far beyond the run
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    final_report;
  end
endmodule : test_osc_pll_dfll_clock_control
